// >>> hdl/fhp_framer.sv
// Module: frame header parser, address filter, auto-ack/auto-retry sequencer and FCS unit
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module fhp_framer #(
   parameter int ACK_TURN_CYC = fhp_pkg::ACK_TURN_CYC,
   parameter int ACK_WAIT_CYC = fhp_pkg::ACK_WAIT_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   input wire fhp_pkg::fhp_bus_s bus_req,
   output logic [15:0] rd_data,
   // Receive bit stream from the demodulator
   input wire fhp_pkg::fhp_rx_s rx_in,
   // Transmit bit stream to the modulator
   output fhp_pkg::fhp_tx_s tx_out,
   input wire logic tx_ready,
   // Events
   output logic rx_frame_end_event
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      fhp_pkg::fhp_tx_state_e st;
      logic [7:0] ctrl;
      logic [15:0] pan;
      logic [15:0] short_adr;
      logic [63:0] ext_adr;
      logic [6:0] txlen;
      logic [6:0] twptr;
      logic [6:0] rptr;
      logic [15:0] rdata;
      logic crc_ok;
      logic rx_end;
      logic tx_done;
      logic [1:0] tx_res;
      logic ack_sent;
      logic sec;
      logic filt;
      logic [4:0] hdrlen;
      logic [6:0] rxlen;
      logic [15:0] rxfcw;
      logic [7:0] rxseq;
      logic end_evt;
      logic ractive;
      logic rphr;
      logic [2:0] rbit;
      logic [6:0] ridx;
      logic [6:0] rlen;
      logic [7:0] rsh;
      logic [15:0] rcrc;
      logic [15:0] pfcw;
      logic [7:0] pseq;
      logic pan_m;
      logic pan_b;
      logic adr_m;
      logic adr_b;
      logic [6:0] tpos;
      logic [6:0] tlen;
      logic [3:0] tcnt;
      logic [15:0] tsh;
      logic [15:0] tcrc;
      logic tcrcph;
      logic tack;
      logic tackreq;
      logic [7:0] tseq;
      logic [7:0] aseq;
      logic apend;
      logic [15:0] timer;
      logic tvalid;
      logic tsof;
      logic teof;
   } fhp_state_s;

   fhp_state_s q;   // Registered state
   fhp_state_s d;   // Next state
   logic [7:0] tx_mem [0:127];   // Frame to send, PSDU bytes
   logic [7:0] rx_mem [0:127];   // Last received PSDU
   logic tb_we;
   logic [6:0] tb_addr;
   logic [7:0] tb_din;
   logic rb_we;
   logic [6:0] rb_addr;
   logic [7:0] rb_din;

   // ****************************************
   // Functions
   // ****************************************
   // One bit of the CRC division, first bit taken as highest coefficient
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      logic fb;
      fb = c[15] ^ b;
      crc_step = {c[14:0], 1'b0} ^ (fb ? fhp_pkg::CRC_POLY : fhp_pkg::CRC_INIT);
   endfunction

   // Byte k of a little-endian address value
   function automatic logic [7:0] byte_of(input logic [63:0] v, input logic [2:0] k);
      byte_of = v[{k, 3'b000} +: 8];
   endfunction

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      logic [7:0] sh_n;
      logic done;
      logic [15:0] f;
      logic [1:0] dm;
      logic [1:0] sm;
      logic [2:0] ft;
      logic [4:0] hdr;
      logic pass;
      logic need_ack;
      logic good;
      logic start_req;
      logic launch;
      logic crc_on;
      logic [6:0] p;
      logic [6:0] k;
      logic [15:0] tcrc_n;
      logic [6:0] dend;
      sh_n = 8'h00;
      done = 1'b0;
      f = 16'h0000;
      dm = 2'h0;
      sm = 2'h0;
      ft = 3'h0;
      hdr = 5'h00;
      pass = 1'b0;
      need_ack = 1'b0;
      good = 1'b0;
      start_req = 1'b0;
      launch = 1'b0;
      crc_on = 1'b0;
      p = 7'h00;
      k = 7'h00;
      tcrc_n = q.tcrc;
      dend = 7'h00;
      d = q;
      d.end_evt = 1'b0;
      d.rdata = 16'h0000;
      tb_we = 1'b0;
      tb_addr = q.twptr;
      tb_din = bus_req.wdata[7:0];
      rb_we = 1'b0;
      rb_addr = q.ridx;
      rb_din = 8'h00;

      // Register writes; clears come first so hardware sets below win
      if (bus_req.wr) begin
         case (bus_req.addr)
            fhp_pkg::REG_CTRL: d.ctrl = bus_req.wdata[7:0];
            fhp_pkg::REG_CMD: start_req = bus_req.wdata[fhp_pkg::CMD_START];
            fhp_pkg::REG_STATUS: begin
               // Write one to clear the sticky events
               if (bus_req.wdata[fhp_pkg::STS_RX_END]) d.rx_end = 1'b0;
               if (bus_req.wdata[fhp_pkg::STS_TX_DONE]) d.tx_done = 1'b0;
               if (bus_req.wdata[fhp_pkg::STS_ACK_SENT]) d.ack_sent = 1'b0;
            end
            fhp_pkg::REG_TXLEN: begin
               d.txlen = bus_req.wdata[6:0];
               d.twptr = 7'h00;
            end
            fhp_pkg::REG_TXDATA: begin
               tb_we = 1'b1;
               d.twptr = q.twptr + 7'h01;
            end
            fhp_pkg::REG_PAN: d.pan = bus_req.wdata;
            fhp_pkg::REG_SHORT: d.short_adr = bus_req.wdata;
            default: begin
               // Extended address words; other offsets are ignored
               if (bus_req.addr >= fhp_pkg::REG_EXT0 && bus_req.addr <= fhp_pkg::REG_EXT3) begin
                  d.ext_adr[{bus_req.addr[1:0] - 2'h3, 4'h0} +: 16] = bus_req.wdata;
               end
            end
         endcase
      end

      // Register reads, answered in the next cycle; unmapped reads give zero
      if (bus_req.rd) begin
         case (bus_req.addr)
            fhp_pkg::REG_CTRL: d.rdata = {8'h00, q.ctrl};
            fhp_pkg::REG_STATUS: d.rdata = {2'b00, q.hdrlen, q.filt, q.sec, q.ack_sent, q.tx_res,
                                            q.tx_done, q.st != fhp_pkg::ST_IDLE, q.rx_end, q.crc_ok};
            fhp_pkg::REG_TXLEN: d.rdata = {9'h000, q.txlen};
            fhp_pkg::REG_RXLEN: d.rdata = {9'h000, q.rxlen};
            fhp_pkg::REG_RXFCW: d.rdata = q.rxfcw;
            fhp_pkg::REG_RXSEQ: d.rdata = {8'h00, q.rxseq};
            fhp_pkg::REG_RXDATA: begin
               // Reading walks the receive buffer
               d.rdata = {8'h00, rx_mem[q.rptr]};
               d.rptr = q.rptr + 7'h01;
            end
            fhp_pkg::REG_PAN: d.rdata = q.pan;
            fhp_pkg::REG_SHORT: d.rdata = q.short_adr;
            default: begin
               if (bus_req.addr >= fhp_pkg::REG_EXT0 && bus_req.addr <= fhp_pkg::REG_EXT3) begin
                  d.rdata = q.ext_adr[{bus_req.addr[1:0] - 2'h3, 4'h0} +: 16];
               end
            end
         endcase
      end

      // Receive: PHR byte, then PSDU bytes LSB first through the CRC
      if (rx_in.sof) begin
         d.ractive = 1'b1;
         d.rphr = 1'b1;
         d.rbit = 3'h0;
         d.ridx = 7'h00;
         d.rcrc = fhp_pkg::CRC_INIT;
         d.pfcw = 16'h0000;
         d.pan_m = 1'b1;
         d.pan_b = 1'b1;
         d.adr_m = 1'b1;
         d.adr_b = 1'b1;
      end else if (rx_in.valid && q.ractive) begin
         sh_n = {rx_in.data, q.rsh[7:1]};
         d.rsh = sh_n;
         d.rbit = q.rbit + 3'h1;
         if (!q.rphr) d.rcrc = crc_step(q.rcrc, rx_in.data);
         if (q.rbit == 3'h7) begin
            if (q.rphr) begin
               d.rlen = sh_n[6:0];
               d.rphr = 1'b0;
               d.ractive = sh_n[6:0] != 7'h00;
            end else begin
               rb_we = 1'b1;
               rb_din = sh_n;
               if (q.ridx == 7'h00) d.pfcw[7:0] = sh_n;
               if (q.ridx == 7'h01) d.pfcw[15:8] = sh_n;
               if (q.ridx == fhp_pkg::SEQ_IDX) d.pseq = sh_n;
               // Destination PAN then address, compared on the fly
               dm = q.pfcw[fhp_pkg::FCW_DMODE +: 2];
               dend = fhp_pkg::DADR_IDX + ((dm == fhp_pkg::AM_EXT) ? 7'h08 : 7'h02);
               if (dm[1] && q.ridx >= fhp_pkg::DPAN_IDX && q.ridx < fhp_pkg::DADR_IDX) begin
                  k = q.ridx - fhp_pkg::DPAN_IDX;
                  d.pan_m = q.pan_m && (sh_n == byte_of({48'h0, q.pan}, k[2:0]));
                  d.pan_b = q.pan_b && (sh_n == 8'hFF);
               end else if (dm[1] && q.ridx >= fhp_pkg::DADR_IDX && q.ridx < dend) begin
                  k = q.ridx - fhp_pkg::DADR_IDX;
                  d.adr_m = q.adr_m && (sh_n == byte_of((dm == fhp_pkg::AM_EXT) ? q.ext_adr
                                                         : {48'h0, q.short_adr}, k[2:0]));
                  d.adr_b = q.adr_b && (sh_n == 8'hFF) && (dm == fhp_pkg::AM_SHORT);
               end
               d.ridx = q.ridx + 7'h01;
               if (q.ridx == q.rlen - 7'h01) begin
                  done = 1'b1;
                  d.ractive = 1'b0;
               end
            end
         end
      end

      // Transmit sequencer
      crc_on = q.tack || q.ctrl[fhp_pkg::CTRL_AUTO_CRC];
      unique case (q.st)
         fhp_pkg::ST_IDLE: begin
            if (start_req) begin
               launch = 1'b1;
               d.tack = 1'b0;
               d.tlen = q.txlen;
               d.tackreq = tx_mem[0][fhp_pkg::FCW_ACKREQ];
               d.tseq = tx_mem[fhp_pkg::SEQ_IDX];
            end
         end
         fhp_pkg::ST_TURN: begin
            // Hold off the acknowledgement for the turnaround time
            d.timer = q.timer + 16'h0001;
            if (q.timer >= 16'(ACK_TURN_CYC - 1)) begin
               launch = 1'b1;
               d.tack = 1'b1;
               d.tlen = fhp_pkg::ACK_LEN;
            end
         end
         fhp_pkg::ST_SEND: begin
            if (tx_ready) begin
               d.tsh = {1'b0, q.tsh[15:1]};
               d.tsof = 1'b0;
               d.tcnt = q.tcnt + 4'h1;
               if (!q.tcrcph && q.tpos != 7'h00) tcrc_n = crc_step(q.tcrc, q.tsh[0]);
               d.tcrc = tcrc_n;
               if (q.tcnt == (q.tcrcph ? 4'hF : 4'h7)) begin
                  d.tcnt = 4'h0;
                  p = q.tpos + 7'h01;
                  if (q.tpos == q.tlen) begin
                     // Frame complete
                     d.tvalid = 1'b0;
                     if (q.tack) begin
                        d.ack_sent = 1'b1;
                        d.st = fhp_pkg::ST_IDLE;
                     end else if (q.ctrl[fhp_pkg::CTRL_AUTO_RETRY] && q.tackreq) begin
                        d.st = fhp_pkg::ST_WAIT;
                        d.timer = 16'h0000;
                     end else begin
                        d.tx_done = 1'b1;
                        d.tx_res = fhp_pkg::RES_SENT;
                        d.st = fhp_pkg::ST_IDLE;
                     end
                  end else if (crc_on && p == q.tlen - 7'h01) begin
                     // FCS replaces the last two buffer bytes, r0 sent first
                     d.tsh = {<<{tcrc_n}};
                     d.tcrcph = 1'b1;
                     d.tpos = q.tlen;
                  end else begin
                     d.tpos = p;
                     d.tsh = {8'h00, q.tack ? ((p == 7'h01) ? {3'b000, q.apend, 4'b0010}
                                             : (p == 7'h02) ? 8'h00 : q.aseq)
                                             : tx_mem[p - 7'h01]};
                  end
               end
               d.teof = d.tvalid && (d.tpos == q.tlen) && (d.tcnt == (d.tcrcph ? 4'hF : 4'h7));
            end
         end
         fhp_pkg::ST_WAIT: begin
            d.timer = q.timer + 16'h0001;
            if (q.timer >= 16'(ACK_WAIT_CYC - 1)) begin
               d.st = fhp_pkg::ST_IDLE;
               d.tx_done = 1'b1;
               d.tx_res = fhp_pkg::RES_NOACK;
            end
         end
         default: d.st = fhp_pkg::ST_IDLE;
      endcase

      // Load the PHR of a new frame; the FCS division restarts with it
      if (launch) begin
         d.st = fhp_pkg::ST_SEND;
         d.tpos = 7'h00;
         d.tcnt = 4'h0;
         d.tsh = {9'h000, d.tlen};
         d.tcrc = fhp_pkg::CRC_INIT;
         d.tcrcph = 1'b0;
         d.tvalid = 1'b1;
         d.tsof = 1'b1;
         d.teof = 1'b0;
      end

      // End of a received frame: filter, report, acknowledge
      if (done) begin
         f = d.pfcw;
         dm = f[fhp_pkg::FCW_DMODE +: 2];
         sm = f[fhp_pkg::FCW_SMODE +: 2];
         ft = f[fhp_pkg::FCW_TYPE +: 3];
         good = d.rcrc == fhp_pkg::CRC_INIT;
         // Header length; source PAN absent when both present and intra-PAN set
         hdr = fhp_pkg::HDR_BASE + ((dm == fhp_pkg::AM_EXT) ? 5'h0A : (dm == fhp_pkg::AM_SHORT) ? 5'h04 : 5'h00)
               + ((sm[1] && !(f[fhp_pkg::FCW_INTRA] && dm[1])) ? 5'h02 : 5'h00)
               + ((sm == fhp_pkg::AM_EXT) ? 5'h08 : (sm == fhp_pkg::AM_SHORT) ? 5'h02 : 5'h00);
         pass = (ft <= fhp_pkg::FT_CMD || q.ctrl[fhp_pkg::CTRL_RES_TYPE])
                && ((dm != fhp_pkg::AM_RSVD && sm != fhp_pkg::AM_RSVD
                     && !(dm == fhp_pkg::AM_NONE && sm == fhp_pkg::AM_NONE && ft != fhp_pkg::FT_ACK)
                     && !(f[fhp_pkg::FCW_SEC] && f[fhp_pkg::FCW_VER +: 2] == fhp_pkg::FV_2003)
                     && {2'b00, hdr} + 7'h02 <= q.rlen)
                    || q.ctrl[fhp_pkg::CTRL_OTHER])
                && (!dm[1] || ((d.pan_m || d.pan_b) && (d.adr_m || d.adr_b)));
         need_ack = good && pass && f[fhp_pkg::FCW_ACKREQ] && !d.adr_b
                    && (ft == fhp_pkg::FT_DATA || ft == fhp_pkg::FT_CMD)
                    && (f[fhp_pkg::FCW_VER +: 2] <= q.ctrl[fhp_pkg::CTRL_FVP +: 2]);
         if (!q.ctrl[fhp_pkg::CTRL_AUTO_ACK] || (good && pass)) begin
            d.end_evt = 1'b1;
            d.rx_end = 1'b1;
            d.crc_ok = good;
            d.rxlen = q.rlen;
            d.rxfcw = f;
            d.rxseq = d.pseq;
            d.sec = f[fhp_pkg::FCW_SEC];
            d.filt = pass;
            d.hdrlen = hdr;
            d.rptr = 7'h00;
         end
         if (q.ctrl[fhp_pkg::CTRL_AUTO_ACK] && need_ack && q.st == fhp_pkg::ST_IDLE) begin
            d.st = fhp_pkg::ST_TURN;
            d.timer = 16'h0000;
            d.aseq = d.pseq;
            d.apend = q.ctrl[fhp_pkg::CTRL_PEND] && ft == fhp_pkg::FT_CMD;
         end
         if (q.st == fhp_pkg::ST_WAIT && good && q.rlen == fhp_pkg::ACK_LEN
             && ft == fhp_pkg::FT_ACK && d.pseq == q.tseq) begin
            d.st = fhp_pkg::ST_IDLE;
            d.tx_done = 1'b1;
            d.tx_res = fhp_pkg::RES_ACKED;
         end
      end
   end

   // ****************************************
   // Registers and buffers
   // ****************************************
   // State register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         q <= '0;
         q.st <= fhp_pkg::ST_IDLE;
         q.ctrl <= fhp_pkg::CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   // Frame buffers carry data only, so they need no reset
   always_ff @(posedge ref_clk) begin
      if (tb_we) tx_mem[tb_addr] <= tb_din;
      if (rb_we) rx_mem[rb_addr] <= rb_din;
   end

   // Outputs straight from flops
   assign rd_data = q.rdata;
   assign rx_frame_end_event = q.end_evt;
   assign tx_out = '{sof: q.tsof, eof: q.teof, valid: q.tvalid, data: q.tsh[0]};
endmodule

// >>> hdl/fhp_pkg.sv
// Package: constants, types and register map of the frame header parser and FCS unit
// Functional notes
// - Auto-ack mode acknowledges frames requesting it
// - Auto-retry waits for ack only if requested
// - Intra-PAN bit drops source PAN identifier
// - Destination mode: none, reserved, short, extended
// - Present address starts with PAN identifier
// - Frame version: 2003, 2006, two reserved
// - Version policy selects which frames get acked
// - Source mode decoded like destination mode
// - Filter uses type, security, intra, modes, version
// - Ack copies received sequence number
// - Destination fields precede source fields
// - No-address frames only acks; others configurable
// - Security header only when security bit set
// - FCS covers PSDU, last two bytes
// - Generator x^16+x^12+x^5+1
// - First bit highest, remainder r0 first
// - Receive CRC result kept in status
// - Transmit appends FCS unless disabled
// - Only frame types 0 to 3 pass; CTRL_RES_TYPE also passes the others
// - CRC over N-2 bytes replaces last two
// - Bad FCS in auto-ack: drop, no event
package fhp_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_TXLEN = 4'h3;
   localparam logic [3:0] REG_TXDATA = 4'h4;
   localparam logic [3:0] REG_RXLEN = 4'h5;
   localparam logic [3:0] REG_RXFCW = 4'h6;
   localparam logic [3:0] REG_RXSEQ = 4'h7;
   localparam logic [3:0] REG_RXDATA = 4'h8;
   localparam logic [3:0] REG_PAN = 4'h9;
   localparam logic [3:0] REG_SHORT = 4'hA;
   localparam logic [3:0] REG_EXT0 = 4'hB;
   localparam logic [3:0] REG_EXT3 = 4'hE;
   // Control bits
   localparam int CTRL_AUTO_ACK = 0;
   localparam int CTRL_AUTO_RETRY = 1;
   localparam int CTRL_AUTO_CRC = 2;
   localparam int CTRL_FVP = 3;
   localparam int CTRL_RES_TYPE = 5;
   localparam int CTRL_OTHER = 6;
   localparam int CTRL_PEND = 7;
   localparam logic [7:0] CTRL_RESET = 8'h04;
   localparam int CMD_START = 0;
   // Status bits
   localparam int STS_CRC_OK = 0;
   localparam int STS_RX_END = 1;
   localparam int STS_TX_DONE = 3;
   localparam int STS_ACK_SENT = 6;
   // ****************************************
   // Frame layout
   // ****************************************
   localparam int FCW_TYPE = 0;
   localparam int FCW_SEC = 3;
   localparam int FCW_ACKREQ = 5;
   localparam int FCW_INTRA = 6;
   localparam int FCW_DMODE = 10;
   localparam int FCW_VER = 12;
   localparam int FCW_SMODE = 14;
   localparam logic [6:0] SEQ_IDX = 7'h02;
   localparam logic [6:0] DPAN_IDX = 7'h03;
   localparam logic [6:0] DADR_IDX = 7'h05;
   localparam logic [6:0] ACK_LEN = 7'h05;
   localparam logic [4:0] HDR_BASE = 5'h03;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   typedef enum logic [1:0] {AM_NONE = 2'h0, AM_RSVD = 2'h1, AM_SHORT = 2'h2, AM_EXT = 2'h3} fhp_amode_e;
   typedef enum logic [2:0] {FT_BEACON = 3'h0, FT_DATA = 3'h1, FT_ACK = 3'h2, FT_CMD = 3'h3} fhp_ftype_e;
   typedef enum logic [1:0] {FV_2003 = 2'h0, FV_2006 = 2'h1, FV_RSVD2 = 2'h2, FV_RSVD3 = 2'h3} fhp_fver_e;
   localparam logic [1:0] RES_ACKED = 2'h0;
   localparam logic [1:0] RES_NOACK = 2'h1;
   localparam logic [1:0] RES_SENT = 2'h2;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 40;
   localparam int ACK_TURN_US = 192;
   localparam int ACK_WAIT_US = 864;
   localparam int ACK_TURN_CYC = ACK_TURN_US * CLK_MHZ;
   localparam int ACK_WAIT_CYC = ACK_WAIT_US * CLK_MHZ;
   typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_TURN = 4'h2, ST_SEND = 4'h4, ST_WAIT = 4'h8} fhp_tx_state_e;
   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {logic [3:0] addr; logic [15:0] wdata; logic wr; logic rd;} fhp_bus_s;
   typedef struct packed {logic sof; logic valid; logic data;} fhp_rx_s;
   typedef struct packed {logic sof; logic eof; logic valid; logic data;} fhp_tx_s;
endpackage

// >>> tb/fhp_framer_assertions.sv
// Checker: port-level timing of the framer bit streams
`timescale 1ns/100ps
module fhp_framer_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Observed streams
   input wire fhp_pkg::fhp_rx_s rx_in,
   input wire fhp_pkg::fhp_tx_s tx_out,
   input wire logic tx_ready,
   input wire logic rx_frame_end_event
);
   logic [9:0] cnt_q; // Bits accepted so far in this frame
   logic [7:0] phr_q; // Length octet seen on the wire
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Count taken bits; idle clears it, so no reset is needed
   always_ff @(posedge ref_clk) begin
      if (!tx_out.valid) begin
         cnt_q <= 10'h000;
      end else if (tx_ready) begin
         cnt_q <= cnt_q + 10'h001;
         if (cnt_q < 10'h008) begin
            phr_q <= {tx_out.data, phr_q[7:1]};
         end
      end
   end
   chk_frame_len: assert property (tx_out.eof && tx_ready |-> cnt_q == {phr_q[6:0], 3'h7})
      else $error("tx length mismatch");
   chk_sof_start: assert property ($rose(tx_out.valid) |-> tx_out.sof && cnt_q == 10'h000)
      else $error("no start mark");
   chk_sof_once: assert property (tx_out.sof && tx_ready |=> !tx_out.sof)
      else $error("start mark too long");
   chk_tx_hold: assert property (tx_out.valid && !tx_ready |=> $stable(tx_out))
      else $error("tx moved in stall");
   chk_tx_stop: assert property (tx_out.eof && tx_ready |=> !tx_out.valid)
      else $error("tx past end");
   chk_tx_runs: assert property (tx_out.valid && !tx_out.eof |=> tx_out.valid)
      else $error("tx frame cut short");
   chk_event_pulse: assert property (rx_frame_end_event |=> !rx_frame_end_event)
      else $error("rx event too long");
   chk_event_cause: assert property (rx_frame_end_event |-> $past(rx_in.valid))
      else $error("rx event with no bit");
   cover property (rx_frame_end_event);
   cover property (tx_out.eof && tx_ready);
   cover property (tx_out.valid && !tx_ready);
endmodule
bind fhp_framer fhp_framer_chk u_fhp_framer_chk (.ref_clk(ref_clk), .reset_n(reset_n), .rx_in(rx_in),
   .tx_out(tx_out), .tx_ready(tx_ready), .rx_frame_end_event(rx_frame_end_event));

// >>> tb/fhp_radio.sv
// Remote radio node: sends frames to the framer and records what it sends back
`timescale 1ns/100ps
module fhp_radio (
   // Clock
   input wire logic ref_clk,
   // Air side
   output fhp_pkg::fhp_rx_s rx_in,
   input wire fhp_pkg::fhp_tx_s tx_out,
   output logic tx_ready,
   // Stall every other cycle when high
   input wire logic slow
);
   logic bits_q[$]; // Received bits in air order
   logic tog_q = 1'b0;
   initial rx_in = '0;
   initial tx_ready = 1'b1;
   // Take bits; a slow receiver stalls every other cycle
   always @(posedge ref_clk) begin
      tog_q <= ~tog_q;
      tx_ready <= ~slow | tog_q;
      if (tx_out.valid && tx_ready) begin
         bits_q.push_back(tx_out.data);
      end
   end
   // One bit of the serial remainder, first bit as top coefficient
   function automatic logic [15:0] step(input logic [15:0] c, input logic b);
      return {c[14:0], 1'b0} ^ ((b ^ c[15]) ? 16'h1021 : 16'h0000);
   endfunction
   task automatic put(input logic v);
      @(posedge ref_clk);
      rx_in <= '{1'b0, 1'b1, v};
   endtask
   // Send length octet, bytes LSB first, then remainder r0 first; bad spoils the last bit
   task automatic send(input logic [7:0] b[$], input logic bad);
      logic [15:0] c;
      c = 16'h0000;
      b.push_front(8'(b.size() + 2));
      @(posedge ref_clk);
      rx_in <= '{1'b1, 1'b0, 1'b0};
      foreach (b[i]) for (int k = 0; k < 8; k++) begin
         if (i > 0) c = step(c, b[i][k]);
         put(b[i][k]);
      end
      for (int k = 15; k >= 0; k--) put(c[k] ^ (bad && k == 0));
      @(posedge ref_clk);
      rx_in <= '{1'b0, 1'b0, ~rx_in.data};
   endtask
endmodule

// >>> tb/tb.sv
// Testbench: register port, receive parsing, transmit FCS and auto acknowledge
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   fhp_pkg::fhp_bus_s bus_req = '0;
   logic [15:0] rd_data, rv;
   fhp_pkg::fhp_rx_s rx_in;
   fhp_pkg::fhp_tx_s tx_out;
   logic tx_ready, rx_frame_end_event;
   logic slow = 1'b0;
   int miscompares = 0;
   int check_count = 0;
   int events = 0;
   logic [15:0] hf[6] = '{16'h0821, 16'hC841, 16'h8801, 16'h8841, 16'h0C01, 16'h0809};
   logic [4:0] hl[6] = '{5'h07, 5'h0F, 5'h0B, 5'h09, 5'h0D, 5'h07};
   logic [15:0] af[5] = '{16'h0821, 16'h0801, 16'h1821, 16'h2821, 16'h0824};
   logic [7:0] ac[5] = '{8'h05, 8'h05, 8'h05, 8'h1D, 8'h05};
   logic ae[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   logic [7:0] td[5] = '{8'h22, 8'h00, 8'h6A, 8'hAA, 8'h55};
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (rx_frame_end_event === 1'b1) events++;
   fhp_framer #(.ACK_TURN_CYC(8), .ACK_WAIT_CYC(40)) u_fhp_framer (.ref_clk(ref_clk), .reset_n(reset_n),
      .bus_req(bus_req), .rd_data(rd_data), .rx_in(rx_in), .tx_out(tx_out), .tx_ready(tx_ready),
      .rx_frame_end_event(rx_frame_end_event));
   fhp_radio u_fhp_radio (.ref_clk(ref_clk), .rx_in(rx_in), .tx_out(tx_out), .tx_ready(tx_ready), .slow(slow));
   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus_req <= '0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge ref_clk);
      bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus_req <= '0;
      @(posedge ref_clk);
      rv = rd_data;
   endtask
   function automatic logic [7:0] byte_at(input int i);
      for (int k = 0; k < 8; k++) byte_at[k] = u_fhp_radio.bits_q[8 * i + k];
   endfunction
   function automatic logic [15:0] fcs_at(input int i);
      fcs_at = 16'h0000;
      for (int k = 0; k < 16; k++) fcs_at = {fcs_at[14:0], u_fhp_radio.bits_q[8 * i + k]};
   endfunction
   function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
      crc_of = 16'h0000;
      foreach (b[i]) for (int k = 0; k < 8; k++) crc_of = u_fhp_radio.step(crc_of, b[i][k]);
   endfunction
   // Five-byte frame with auto CRC on or off, stalled receiver
   task automatic t_tx(input logic [7:0] ctrl);
      slow <= 1'b1;
      wr(fhp_pkg::REG_CTRL, {8'h00, ctrl});
      u_fhp_radio.bits_q.delete();
      wr(fhp_pkg::REG_TXLEN, 16'h0005);
      foreach (td[i]) wr(fhp_pkg::REG_TXDATA, {8'h00, td[i]});
      wr(fhp_pkg::REG_CMD, 16'h0001);
      repeat (200) @(posedge ref_clk);
      check(16'(u_fhp_radio.bits_q.size()), 16'h0030);
      check(byte_at(0), 8'h05);
      check(byte_at(3), 8'h6A);
      if (ctrl[2]) check(fcs_at(4), 16'hFB5E);
      else check(fcs_at(4), 16'h55AA);
      rd(fhp_pkg::REG_STATUS);
      check(rv[5:3], ctrl[2] ? 3'h5 : 3'h3);
      wr(fhp_pkg::REG_STATUS, 16'h004A);
      slow <= 1'b0;
   endtask
   // Basic mode: header length for five addressing layouts and a secured frame, then a spoiled frame
   task automatic t_rx;
      logic [7:0] f[$];
      int n;
      wr(fhp_pkg::REG_CTRL, 16'h0004);
      for (int i = 0; i <= 6; i++) begin
         f = {hf[i % 6][7:0], hf[i % 6][15:8], 8'h5A};
         for (int k = 0; k < 14; k++) f.push_back(8'(k));
         n = events;
         u_fhp_radio.send(f, i == 6);
         repeat (2) @(posedge ref_clk);
         check(events, n + 1);
         rd(fhp_pkg::REG_STATUS);
         check(rv[0], i != 6);
         if (i < 6) check({rv[13:9], rv[7]}, {hl[i], hf[i][3]});
      end
      rd(fhp_pkg::REG_RXFCW);
      check(rv, 16'h0821);
   endtask
   // Auto-ack: bad frame dropped, then acks by request, version and type
   task automatic t_ack;
      logic [7:0] f[$];
      int n;
      wr(fhp_pkg::REG_PAN, 16'h1234);
      wr(fhp_pkg::REG_SHORT, 16'h0001);
      wr(fhp_pkg::REG_CTRL, 16'h0005);
      f = {8'h21, 8'h08, 8'h5A, 8'h34, 8'h12, 8'h01, 8'h00};
      u_fhp_radio.bits_q.delete();
      n = events;
      u_fhp_radio.send(f, 1'b1);
      repeat (100) @(posedge ref_clk);
      check(events, n);
      check(16'(u_fhp_radio.bits_q.size()), 16'd0);
      for (int i = 0; i < 5; i++) begin
         wr(fhp_pkg::REG_CTRL, {8'h00, ac[i]});
         u_fhp_radio.bits_q.delete();
         f[0] = af[i][7:0];
         f[1] = af[i][15:8];
         f[2] = 8'h60 + 8'(i);
         u_fhp_radio.send(f, 1'b0);
         repeat (100) @(posedge ref_clk);
         check(16'(u_fhp_radio.bits_q.size()), ae[i] ? 16'd48 : 16'd0);
         if (ae[i]) begin
            check({byte_at(1), byte_at(3)}, {8'h02, f[2]});
            check(fcs_at(4), crc_of({8'h02, 8'h00, f[2]}));
         end
      end
   endtask
   task stop_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      stop_test;
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(fhp_pkg::REG_CTRL);
      check(rv, 16'h0004);
      rd(4'hF);
      check(rv, 16'h0000);
      t_tx(8'h04);
      t_tx(8'h02);
      t_rx;
      t_ack;
      stop_test;
   end
endmodule
